//--- hw/code_guard_pkg.sv
// Package for the code block write and table-read guard.
// Assumes a 22-bit byte address space and 8-bit configuration bytes.
package code_guard_pkg;

    // ********************************************************
    // Widths
    // ********************************************************
    localparam int ADDR_W = 22;                         // Byte address width
    localparam int DATA_W = 8;                          // Config byte width

    // ********************************************************
    // Region bounds
    // ********************************************************
    localparam logic [ADDR_W-1:0] BOOT_LO       = 22'h000000;   // Boot block start
    localparam logic [ADDR_W-1:0] BOOT_HI       = 22'h0001FF;   // Boot block end
    localparam logic [ADDR_W-1:0] BLK0_LO       = 22'h000200;   // Block 0 start, both variants
    localparam logic [ADDR_W-1:0] BLK0_HI_BIG   = 22'h000FFF;   // Block 0 end, larger variant
    localparam logic [ADDR_W-1:0] BLK1_LO_BIG   = 22'h001000;   // Block 1 start, larger variant
    localparam logic [ADDR_W-1:0] BLK1_HI_BIG   = 22'h001FFF;   // Block 1 end, larger variant
    localparam logic [ADDR_W-1:0] BLK0_HI_SMALL = 22'h0007FF;   // Block 0 end, smaller variant
    localparam logic [ADDR_W-1:0] BLK1_LO_SMALL = 22'h000800;   // Block 1 start, smaller variant
    localparam logic [ADDR_W-1:0] BLK1_HI_SMALL = 22'h000FFF;   // Block 1 end, smaller variant
    localparam logic [ADDR_W-1:0] CFG_LO        = 22'h300000;   // Config space start
    localparam logic [ADDR_W-1:0] CFG_HI        = 22'h3000FF;   // Config space end

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [ADDR_W-1:0] PROG_GUARD_OFS    = 22'h30000A; // program_block_write_guard
    localparam logic [ADDR_W-1:0] SPECIAL_GUARD_OFS = 22'h30000B; // special_region_write_guard
    localparam logic [ADDR_W-1:0] TREAD_GUARD_OFS   = 22'h30000C; // block_table_read_guard

    // ********************************************************
    // Field positions and masks
    // ********************************************************
    localparam int BLK0_BIT   = 0;                      // Block 0 guard bit
    localparam int BLK1_BIT   = 1;                      // Block 1 guard bit
    localparam int EEPROM_BIT = 7;                      // Data EEPROM write guard
    localparam int BOOT_BIT   = 6;                      // Boot block write guard
    localparam int CFGSP_BIT  = 5;                      // Config space write guard

    localparam logic [DATA_W-1:0] PROG_GUARD_MASK    = 8'h03; // Implemented bits
    localparam logic [DATA_W-1:0] SPECIAL_GUARD_MASK = 8'hE0; // Implemented bits
    localparam logic [DATA_W-1:0] SPECIAL_SELF_MASK  = 8'hC0; // Bits running code may change
    localparam logic [DATA_W-1:0] CFGSP_MASK         = 8'h20; // Program-mode-only bit
    localparam logic [DATA_W-1:0] TREAD_GUARD_MASK   = 8'h03; // Implemented bits
    localparam logic [DATA_W-1:0] READ_ZERO          = 8'h00; // Unmapped read value

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        REG_BOOT,
        REG_BLK0,
        REG_BLK1,
        REG_CFG,
        REG_OTHER
    } region_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;                        // Register byte address
        logic [DATA_W-1:0] wdata;                       // Write data
        logic              wr;                          // Write strobe
        logic              rd;                          // Read strobe
    } reg_bus_t;

    typedef struct packed {
        logic              valid;                       // Access request
        logic              write;                       // 1 write, 0 table read
        logic              eeprom;                      // Target is data EEPROM
        logic [ADDR_W-1:0] addr;                        // Target address
        logic [ADDR_W-1:0] fetchAddr;                   // Address of issuing code
    } access_req_t;

    typedef struct packed {
        logic valid;                                    // Verdict present
        logic granted;                                  // Access allowed
        logic denied;                                   // Access refused
    } access_resp_t;

    typedef struct packed {
        logic [DATA_W-1:0] progGuard;                   // Block write guards
        logic [DATA_W-1:0] specialGuard;                // EEPROM, boot, config guards
        logic [DATA_W-1:0] treadGuard;                  // Table-read guards
        logic [DATA_W-1:0] rdData;                      // Read data register
        access_resp_t      resp;                        // Verdict register
    } guard_state_t;

    // Unprogrammed state: every implemented bit is 1
    localparam guard_state_t GUARD_STATE_RST = '{
        progGuard:    PROG_GUARD_MASK,
        specialGuard: SPECIAL_GUARD_MASK,
        treadGuard:   TREAD_GUARD_MASK,
        rdData:       READ_ZERO,
        resp:         '{valid: 1'b0, granted: 1'b0, denied: 1'b0}
    };

endpackage

//--- hw/region_decoder.sv
// Address to memory region decoder.
// Assumes the variant is fixed at build time by BIG_VARIANT.
`timescale 1ns/1ps
module region_decoder
    import code_guard_pkg::*;
#(
    parameter bit BIG_VARIANT = 1'b1                    // 1 larger memory, 0 smaller
) (
    input  wire logic [ADDR_W-1:0] addr,
    output region_t                region
);

    // ********************************************************
    // Decode
    // ********************************************************

    // Bounds of the two program blocks for this variant
    localparam logic [ADDR_W-1:0] B0HI = BIG_VARIANT ? BLK0_HI_BIG : BLK0_HI_SMALL;
    localparam logic [ADDR_W-1:0] B1LO = BIG_VARIANT ? BLK1_LO_BIG : BLK1_LO_SMALL;
    localparam logic [ADDR_W-1:0] B1HI = BIG_VARIANT ? BLK1_HI_BIG : BLK1_HI_SMALL;

    // Pick the region holding the address
    always_comb begin
        if (addr <= BOOT_HI) begin
            region = REG_BOOT;
        end else if (addr >= BLK0_LO && addr <= B0HI) begin
            region = REG_BLK0;
        end else if (addr >= B1LO && addr <= B1HI) begin
            region = REG_BLK1;
        end else if (addr >= CFG_LO && addr <= CFG_HI) begin
            region = REG_CFG;
        end else begin
            region = REG_OTHER;
        end
    end

endmodule

//--- hw/code_block_write_read_guard.sv
// Write guard for program memory, data EEPROM and config space; table-read guard for the two program blocks.
// Assumes a core presenting one access per cycle and a plain register port.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module code_block_write_read_guard
    import code_guard_pkg::*;
#(
    parameter bit BIG_VARIANT = 1'b1                    // 1 larger memory, 0 smaller
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          progMode,
    input  wire reg_bus_t      regBus,
    output logic [DATA_W-1:0]  rdData,
    input  wire access_req_t   req,
    output access_resp_t       resp
);

    // ********************************************************
    // State and decode
    // ********************************************************
    guard_state_t state_r;                              // All registered state
    guard_state_t state_nxt;                            // Next state
    region_t      tgtRegion;                            // Region of the target
    region_t      srcRegion;                            // Region of the issuing code
    logic         allow;                                // Verdict before the register
    logic         cfgSelfOk;                            // Config space writable now

    // Target address region
    region_decoder #(
        .BIG_VARIANT (BIG_VARIANT)
    ) u_tgtDecode (
        .addr   (req.addr),
        .region (tgtRegion)
    );

    // Fetch address region
    region_decoder #(
        .BIG_VARIANT (BIG_VARIANT)
    ) u_srcDecode (
        .addr   (req.fetchAddr),
        .region (srcRegion)
    );

    assign cfgSelfOk = state_r.specialGuard[CFGSP_BIT];

    // ********************************************************
    // Access verdict
    // ********************************************************

    // Decide whether the presented access may proceed
    always_comb begin
        allow = 1'b1;
        if (req.eeprom) begin
            // Table reads of EEPROM are not guarded here
            allow = req.write ? state_r.specialGuard[EEPROM_BIT] : 1'b1;
        end else if (req.write) begin
            case (tgtRegion)
                REG_BOOT: allow = state_r.specialGuard[BOOT_BIT];
                REG_BLK0: allow = state_r.progGuard[BLK0_BIT];
                REG_BLK1: allow = state_r.progGuard[BLK1_BIT];
                REG_CFG:  allow = progMode || cfgSelfOk;
                default:  allow = 1'b1;             // Unguarded space
            endcase
        end else begin
            case (tgtRegion)
                // Own-block reads pass whatever the guard says
                REG_BLK0: allow = state_r.treadGuard[BLK0_BIT] || srcRegion == REG_BLK0;
                REG_BLK1: allow = state_r.treadGuard[BLK1_BIT] || srcRegion == REG_BLK1;
                default:  allow = 1'b1;             // Not guarded by this block
            endcase
        end
    end

    // ********************************************************
    // Next state
    // ********************************************************

    // Register writes, read data and verdict
    always_comb begin
        state_nxt = state_r;
        state_nxt.resp.valid   = req.valid;
        state_nxt.resp.granted = req.valid && allow;
        state_nxt.resp.denied  = req.valid && !allow;

        // Writes: program mode sees all bits, running code all but bit 5 and only when unguarded
        if (regBus.wr) begin
            case (regBus.addr)
                PROG_GUARD_OFS: begin
                    if (progMode || cfgSelfOk) begin
                        state_nxt.progGuard = regBus.wdata & PROG_GUARD_MASK;
                    end
                end
                SPECIAL_GUARD_OFS: begin
                    if (progMode) begin
                        state_nxt.specialGuard = regBus.wdata & SPECIAL_GUARD_MASK;
                    end else if (cfgSelfOk) begin
                        // Config-space guard bit is kept as is
                        state_nxt.specialGuard = (regBus.wdata & SPECIAL_SELF_MASK)
                                               | (state_r.specialGuard & CFGSP_MASK);
                    end
                end
                TREAD_GUARD_OFS: begin
                    if (progMode || cfgSelfOk) begin
                        state_nxt.treadGuard = regBus.wdata & TREAD_GUARD_MASK;
                    end
                end
                default: begin
                    // Unmapped writes are ignored
                end
            endcase
        end

        // Reads: data stand for the following cycle only
        state_nxt.rdData = READ_ZERO;
        if (regBus.rd) begin
            case (regBus.addr)
                PROG_GUARD_OFS:    state_nxt.rdData = state_r.progGuard & PROG_GUARD_MASK;
                SPECIAL_GUARD_OFS: state_nxt.rdData = state_r.specialGuard & SPECIAL_GUARD_MASK;
                TREAD_GUARD_OFS:   state_nxt.rdData = state_r.treadGuard & TREAD_GUARD_MASK;
                default:           state_nxt.rdData = READ_ZERO; // Unmapped reads zero
            endcase
        end
    end

    // ********************************************************
    // State register
    // ********************************************************

    // Reset loads the unprogrammed pattern
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= GUARD_STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rdData = state_r.rdData;
    assign resp   = state_r.resp;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Program write landing in a range
    sequence s_wr_hit(logic [ADDR_W-1:0] lo, logic [ADDR_W-1:0] hi);
        req.valid && req.write && !req.eeprom && req.addr >= lo && req.addr <= hi;
    endsequence

    // Table read of a range from code outside another range
    sequence s_rd_foreign(logic [ADDR_W-1:0] lo, logic [ADDR_W-1:0] hi,
                          logic [ADDR_W-1:0] slo, logic [ADDR_W-1:0] shi);
        req.valid && !req.write && !req.eeprom && req.addr >= lo && req.addr <= hi
        && !(req.fetchAddr >= slo && req.fetchAddr <= shi);
    endsequence

    // Verdict one cycle later
    sequence s_verdict(logic ok);
        ##1 resp.valid && resp.granted == $past(ok) && resp.denied == !$past(ok);
    endsequence

    a_blk1_wr_big: assert property (
        BIG_VARIANT and s_wr_hit(BLK1_LO_BIG, BLK1_HI_BIG)
        |-> s_verdict(state_r.progGuard[BLK1_BIT]))
        else $error("Block 1 write verdict wrong, larger variant");

    a_blk0_wr_big: assert property (
        BIG_VARIANT and s_wr_hit(BLK0_LO, BLK0_HI_BIG)
        |-> s_verdict(state_r.progGuard[BLK0_BIT]))
        else $error("Block 0 write verdict wrong, larger variant");

    a_blk1_wr_small: assert property (
        !BIG_VARIANT and s_wr_hit(BLK1_LO_SMALL, BLK1_HI_SMALL)
        |-> s_verdict(state_r.progGuard[BLK1_BIT]))
        else $error("Block 1 write verdict wrong, smaller variant");

    a_blk0_wr_small: assert property (
        !BIG_VARIANT and s_wr_hit(BLK0_LO, BLK0_HI_SMALL)
        |-> s_verdict(state_r.progGuard[BLK0_BIT]))
        else $error("Block 0 write verdict wrong, smaller variant");

    a_eeprom_wr_guard: assert property (
        req.valid && req.write && req.eeprom
        |=> resp.granted == $past(state_r.specialGuard[EEPROM_BIT]))
        else $error("EEPROM write verdict wrong");

    a_boot_wr_guard: assert property (
        s_wr_hit(BOOT_LO, BOOT_HI) |-> s_verdict(state_r.specialGuard[BOOT_BIT]))
        else $error("Boot block write verdict wrong");

    a_cfg_wr_guard: assert property (
        s_wr_hit(CFG_LO, CFG_HI) and (!progMode && !state_r.specialGuard[CFGSP_BIT])
        |=> resp.denied && !resp.granted)
        else $error("Guarded config write not refused");

    a_cfgsp_bit_hold: assert property (
        !progMode && regBus.wr && regBus.addr == SPECIAL_GUARD_OFS
        |=> $stable(state_r.specialGuard[CFGSP_BIT]))
        else $error("Running code changed config guard bit");

    a_cfgsp_bit_prog: assert property (
        progMode && regBus.wr && regBus.addr == SPECIAL_GUARD_OFS
        |=> state_r.specialGuard[CFGSP_BIT] == $past(regBus.wdata[CFGSP_BIT]))
        else $error("Program mode write of config guard bit lost");

    a_blk0_rd_big: assert property (
        BIG_VARIANT and s_rd_foreign(BLK0_LO, BLK0_HI_BIG, BLK0_LO, BLK0_HI_BIG)
        |-> s_verdict(state_r.treadGuard[BLK0_BIT]))
        else $error("Foreign read of block 0 verdict wrong, larger variant");

    a_blk1_rd_big: assert property (
        BIG_VARIANT and s_rd_foreign(BLK1_LO_BIG, BLK1_HI_BIG, BLK1_LO_BIG, BLK1_HI_BIG)
        |-> s_verdict(state_r.treadGuard[BLK1_BIT]))
        else $error("Foreign read of block 1 verdict wrong, larger variant");

    a_blk1_rd_small: assert property (
        !BIG_VARIANT and s_rd_foreign(BLK1_LO_SMALL, BLK1_HI_SMALL, BLK1_LO_SMALL, BLK1_HI_SMALL)
        |-> s_verdict(state_r.treadGuard[BLK1_BIT]))
        else $error("Foreign read of block 1 verdict wrong, smaller variant");

    a_blk0_rd_small: assert property (
        !BIG_VARIANT and s_rd_foreign(BLK0_LO, BLK0_HI_SMALL, BLK0_LO, BLK0_HI_SMALL)
        |-> s_verdict(state_r.treadGuard[BLK0_BIT]))
        else $error("Foreign read of block 0 verdict wrong, smaller variant");

    a_unused_read_zero: assert property (
        regBus.rd && regBus.addr == SPECIAL_GUARD_OFS
        |=> rdData[4:0] == 5'h00 ##1 rdData == READ_ZERO || $past(regBus.rd))
        else $error("Unused guard bits not zero");

    a_reset_unprog: assert property (
        $rose(rst_n) |-> state_r.progGuard == PROG_GUARD_MASK
        && state_r.specialGuard == SPECIAL_GUARD_MASK && state_r.treadGuard == TREAD_GUARD_MASK)
        else $error("Guards not unprogrammed after reset");

    a_same_block_rd: assert property (
        req.valid && !req.write && !req.eeprom && tgtRegion == srcRegion
        |-> s_verdict(1'b1))
        else $error("Same-block table read refused");

    // ********************************************************
    // Response, read-port shape and locked writes
    // ********************************************************

    // Every taken access gets exactly one verdict bit
    a_verdict_onehot: assert property (
        req.valid |=> resp.valid && resp.granted != resp.denied)
        else $error("Verdict missing or not one-hot");

    // No verdict without a request
    a_verdict_idle: assert property (
        !req.valid |=> !resp.valid && !resp.granted && !resp.denied)
        else $error("Verdict without a request");

    // Read data fall back to zero when no read was taken
    a_rd_idle_zero: assert property (
        !regBus.rd |=> rdData == READ_ZERO)
        else $error("Read data not zero when idle");

    // No guard byte ever shows bits 4 to 2
    a_unused_mid_zero: assert property (
        rdData[4:2] == 3'h0)
        else $error("Unimplemented guard bits read one");

    // Locked config space: running code changes no guard byte
    a_locked_regs_hold: assert property (
        regBus.wr && !progMode && !cfgSelfOk
        |=> $stable(state_r.progGuard) && $stable(state_r.specialGuard) && $stable(state_r.treadGuard))
        else $error("Guard byte changed while config space locked");

    // Block write guard reads back as stored
    a_prog_read_back: assert property (
        regBus.rd && regBus.addr == PROG_GUARD_OFS
        |=> rdData == $past(state_r.progGuard))
        else $error("Block write guard read back wrong");

    // Table-read guard reads back as stored
    a_tread_read_back: assert property (
        regBus.rd && regBus.addr == TREAD_GUARD_OFS
        |=> rdData == $past(state_r.treadGuard))
        else $error("Table-read guard read back wrong");

endmodule

//--- test/core_model.sv
// Core model that issues self-writes and table reads to one guard.
// Assumes the guard answers one cycle after the taking edge.
`timescale 1ns/1ps
module core_model
    import code_guard_pkg::*;
(
    input  wire logic         clk,
    output access_req_t       req,
    input  wire access_resp_t resp
);
    // ********************************************************
    // Idle request at time zero
    // ********************************************************
    initial begin
        req = '0;
    end

    // ********************************************************
    // One access: held until taken, verdict sampled a cycle on
    // ********************************************************
    task automatic access(input logic w, input logic ee, input logic [ADDR_W-1:0] a,
                          input logic [ADDR_W-1:0] f, output access_resp_t r);
        @(posedge clk);
        req <= '{valid: 1'b1, write: w, eeprom: ee, addr: a, fetchAddr: f};
        @(posedge clk);
        req.valid <= 1'b0;          // Taken at this edge
        req.addr  <= ~a;            // Released lines no longer show the address
        req.fetchAddr <= ~f;
        @(posedge clk);
        r = resp;                   // Verdict stands one cycle
    endtask
endmodule

//--- test/tb_code_block_write_read_guard.sv
// Self-checking bench: both memory variants side by side, one core model each.
// Assumes a shared register port and program-mode input for both guards.
`timescale 1ns/1ps
module tb_code_block_write_read_guard;
    import code_guard_pkg::*;
    logic              clk;         // 50 MHz clock
    logic              rst_n;       // Synchronous reset
    logic              progMode;    // Programmer present
    reg_bus_t          regBus;      // Shared register port
    logic [DATA_W-1:0] rdBig;       // Larger variant read data
    logic [DATA_W-1:0] rdSmall;     // Smaller variant read data
    access_req_t       reqBig;      // Larger variant request
    access_req_t       reqSmall;    // Smaller variant request
    access_resp_t      respBig;     // Larger variant verdict
    access_resp_t      respSmall;   // Smaller variant verdict
    int                errCount;    // Mismatches
    int                testsRun;    // Comparisons

    // ********************************************************
    // Instances
    // ********************************************************
    code_block_write_read_guard #(.BIG_VARIANT(1'b1)) dut (.clk(clk), .rst_n(rst_n), .progMode(progMode),
        .regBus(regBus), .rdData(rdBig), .req(reqBig), .resp(respBig));
    code_block_write_read_guard #(.BIG_VARIANT(1'b0)) dutSmall (.clk(clk), .rst_n(rst_n),
        .progMode(progMode), .regBus(regBus), .rdData(rdSmall), .req(reqSmall), .resp(respSmall));
    core_model core (.clk(clk), .req(reqBig), .resp(respBig));
    core_model coreSmall (.clk(clk), .req(reqSmall), .resp(respSmall));

    // Clock
    always #10 clk = ~clk;

    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regBus.wr <= 1'b0;
    endtask

    // Read both variants, data stands in the next cycle only
    task automatic regRead(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge clk);
        regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        regBus.rd <= 1'b0;
        @(posedge clk);
        check(rdBig, exp);
        check(rdSmall, exp);
    endtask

    // One access on both variants; gB and gS are the expected grants
    task automatic acc(input logic w, input logic ee, input logic [ADDR_W-1:0] a,
                       input logic [ADDR_W-1:0] f, input logic gB, input logic gS);
        access_resp_t rB;
        access_resp_t rS;
        fork
            core.access(w, ee, a, f, rB);
            coreSmall.access(w, ee, a, f, rS);
        join
        check({5'h00, rB}, {5'h00, 1'b1, gB, ~gB});
        check({5'h00, rS}, {5'h00, 1'b1, gS, ~gS});
    endtask

    task automatic setMode(input logic m);
        @(posedge clk);
        progMode <= m;              // Programmer enters or leaves program mode
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic testReset();
        regRead(PROG_GUARD_OFS, 8'h03);
        regRead(SPECIAL_GUARD_OFS, 8'hE0);
        regRead(TREAD_GUARD_OFS, 8'h03);
        regRead(22'h300009, 8'h00);
        acc(1'b1, 1'b0, 22'h0001FF, 22'h0, 1'b1, 1'b1);
        acc(1'b1, 1'b1, 22'h0, 22'h0, 1'b1, 1'b1);
        regWrite(PROG_GUARD_OFS, 8'hFF);
        regRead(PROG_GUARD_OFS, 8'h03);
    endtask

    task automatic testWriteGuards();
        regWrite(PROG_GUARD_OFS, 8'h00);
        regWrite(SPECIAL_GUARD_OFS, 8'h00);
        regRead(SPECIAL_GUARD_OFS, 8'h20);
        acc(1'b1, 1'b0, 22'h000100, 22'h0, 1'b0, 1'b0);
        acc(1'b1, 1'b1, 22'h0, 22'h0, 1'b0, 1'b0);
        acc(1'b1, 1'b0, 22'h000200, 22'h0, 1'b0, 1'b0);
        acc(1'b1, 1'b0, 22'h000800, 22'h0, 1'b0, 1'b0);
        acc(1'b1, 1'b0, 22'h001FFF, 22'h0, 1'b0, 1'b1);
        acc(1'b1, 1'b0, 22'h300000, 22'h0, 1'b1, 1'b1);
        regWrite(PROG_GUARD_OFS, 8'h01);
        acc(1'b1, 1'b0, 22'h000FFF, 22'h0, 1'b1, 1'b0);
        acc(1'b1, 1'b0, 22'h001000, 22'h0, 1'b0, 1'b1);
        regWrite(PROG_GUARD_OFS, 8'h02);
        acc(1'b1, 1'b0, 22'h000FFF, 22'h0, 1'b0, 1'b1);
        acc(1'b1, 1'b0, 22'h0007FF, 22'h0, 1'b0, 1'b0);
        acc(1'b1, 1'b0, 22'h001000, 22'h0, 1'b1, 1'b1);
        regWrite(SPECIAL_GUARD_OFS, 8'hC0);
        acc(1'b1, 1'b1, 22'h0, 22'h0, 1'b1, 1'b1);
        acc(1'b1, 1'b0, 22'h0001FF, 22'h0, 1'b1, 1'b1);
    endtask

    task automatic testConfigGuard();
        setMode(1'b1);
        regWrite(SPECIAL_GUARD_OFS, 8'h00);
        setMode(1'b0);
        regRead(SPECIAL_GUARD_OFS, 8'h00);
        acc(1'b1, 1'b0, 22'h3000FF, 22'h0, 1'b0, 1'b0);
        acc(1'b1, 1'b0, 22'h300100, 22'h0, 1'b1, 1'b1);
        regWrite(SPECIAL_GUARD_OFS, 8'hE0);
        regRead(SPECIAL_GUARD_OFS, 8'h00);
        regWrite(PROG_GUARD_OFS, 8'h03);
        regRead(PROG_GUARD_OFS, 8'h02);
        setMode(1'b1);
        acc(1'b1, 1'b0, 22'h300000, 22'h0, 1'b1, 1'b1);
        regWrite(SPECIAL_GUARD_OFS, 8'hFF);
        regWrite(PROG_GUARD_OFS, 8'hFF);
        setMode(1'b0);
        regRead(SPECIAL_GUARD_OFS, 8'hE0);
    endtask

    task automatic testTableReads();
        regWrite(TREAD_GUARD_OFS, 8'h00);
        acc(1'b0, 1'b0, 22'h000300, 22'h001100, 1'b0, 1'b0);
        acc(1'b0, 1'b0, 22'h001100, 22'h000300, 1'b0, 1'b1);
        acc(1'b0, 1'b0, 22'h000900, 22'h000300, 1'b1, 1'b0);
        acc(1'b0, 1'b0, 22'h000300, 22'h000400, 1'b1, 1'b1);
        acc(1'b0, 1'b0, 22'h000300, 22'h000100, 1'b0, 1'b0);
        acc(1'b0, 1'b0, 22'h001FFF, 22'h001000, 1'b1, 1'b1);
        regWrite(TREAD_GUARD_OFS, 8'hFD);
        regRead(TREAD_GUARD_OFS, 8'h01);
        acc(1'b0, 1'b0, 22'h000300, 22'h001100, 1'b1, 1'b1);
        acc(1'b0, 1'b0, 22'h001100, 22'h000300, 1'b0, 1'b1);
        acc(1'b0, 1'b0, 22'h000900, 22'h000300, 1'b1, 1'b0);
    endtask

    // Second reset in mid-run restores the unprogrammed pattern
    task automatic testMidReset();
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        regRead(TREAD_GUARD_OFS, 8'h03);
    endtask

    // ********************************************************
    // Verdict, watchdog and main sequence
    // ********************************************************
    task automatic summarize();
        if (errCount == 0 && testsRun > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errCount++;
        summarize();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        progMode = 1'b0;
        regBus = '0;
        errCount = 0;
        testsRun = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        testReset();
        testWriteGuards();
        testConfigGuard();
        testTableReads();
        testMidReset();
        summarize();
    end
endmodule
